//--- rtl/pkpd_power_key_decoder.sv
`timescale 1ns/1ps
`include "pkpd_defines.svh"
module pkpd_power_key_decoder
    import pkpd_pkg::*;
#(
    parameter longint unsigned ON_MIN_CYC    = `PKPD_CYC_UP(`PKPD_ON_MIN_MS),
    parameter longint unsigned ON_MAX_CYC    = `PKPD_CYC_DN(`PKPD_ON_MAX_MS),
    parameter longint unsigned PROMPT_CYC    = `PKPD_CYC_UP(`PKPD_PROMPT_MS),
    parameter longint unsigned FORCE_MIN_CYC = `PKPD_CYC_UP(`PKPD_FORCE_MIN_MS),
    parameter longint unsigned FORCE_MAX_CYC = `PKPD_CYC_DN(`PKPD_FORCE_MAX_MS),
    parameter longint unsigned TAP_CYC       = `PKPD_CYC_UP(`PKPD_TAP_MS),
    parameter longint unsigned MS_CYC        = `PKPD_MS_DIV,
    parameter int unsigned     DEB_CYC       = 32'(`PKPD_CYC_UP(`PKPD_DEB_MS))
) (
    // Clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  rst,
    // Key pins, active low
    input  wire logic                  power_key_n,
    input  wire logic                  volume_up_key_n,
    input  wire logic                  volume_down_key_n,
    // Software settings
    input  wire logic                  autoSleepEn,
    input  wire pkpd_pkg::pkpd_idle_t  autoSleepMs,
    input  wire logic                  softShutdown,
    // Power state
    output pkpd_pkg::pkpd_state_e      powerState,
    output logic                       powerOnReq,
    output logic                       forceOffReq,
    output logic                       sleepReq,
    output logic                       wakeReq,
    // Software events
    output logic                       promptReq,
    output logic                       volumeUpEvt,
    output logic                       volumeDownEvt
);
    import pkpd_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Power key synchroniser

    logic        pwrSyncA;
    logic        pwrSyncB;
    logic        pwrHeld;
    pkpd_cnt_t   holdCnt;
    logic        promptSent;
    logic        forceSent;
    pkpd_idle_t  idleMs;
    logic [19:0] msDiv;
    pkpd_state_e next_powerState;

    // Both edges of the key seen through three flops
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pwrSyncA <= 1'b1;
            pwrSyncB <= 1'b1;
            pwrHeld  <= 1'b0;
        end else begin
            pwrSyncA <= power_key_n;
            pwrSyncB <= pwrSyncA;
            pwrHeld  <= ~pwrSyncB;  // (R1)
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Hold duration and window decode

    function automatic logic inWin(pkpd_cnt_t c, longint unsigned lo, longint unsigned hi);
        inWin = (64'(c) >= lo) && (64'(c) <= hi);
    endfunction

    wire pressing   = pwrHeld;
    wire releasing  = ~pwrHeld && (holdCnt != '0);
    wire atMax      = (holdCnt == {`PKPD_CNT_W{1'b1}});
    wire onWin      = inWin(holdCnt, ON_MIN_CYC, ON_MAX_CYC);        // (R2)
    wire forceHit   = pressing && (64'(holdCnt) == FORCE_MIN_CYC);   // (R4)
    wire promptHit  = pressing && (64'(holdCnt) == PROMPT_CYC);      // (R3)
    wire tapWin     = (64'(holdCnt) >= TAP_CYC) && (64'(holdCnt) < PROMPT_CYC);
    wire msTick     = (64'(msDiv) == MS_CYC - 1);
    wire idleDone   = autoSleepEn && (idleMs >= autoSleepMs);

    // Counts cycles the key is held; it saturates instead of wrapping
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            holdCnt <= '0;
        end else if (pressing) begin
            holdCnt <= atMax ? holdCnt : holdCnt + 1'b1;
        end else begin
            holdCnt <= '0;
        end
    end

    // Millisecond tick for the idle timer
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            msDiv <= 20'h00000;
        end else begin
            msDiv <= msTick ? 20'h00000 : msDiv + 20'h00001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State machine

    // A force-off fires once while held; beyond 15 s it is not repeated
    wire doForce = forceHit && (powerState != PKPD_OFF) && !forceSent;       // (R4)
    wire doOn    = releasing && onWin && (powerState == PKPD_OFF);           // (R2)
    wire doTapSl = releasing && tapWin && (powerState == PKPD_STANDBY);      // (R5)
    wire doAuto  = idleDone && msTick && (powerState == PKPD_STANDBY)
                   && !pressing;                                             // (R7)
    wire doWake  = releasing && tapWin && (powerState == PKPD_SLEEPING);     // (R6)
    wire doSoft  = softShutdown && (powerState != PKPD_OFF);

    // Anything not matched above leaves the state alone
    always_comb begin
        next_powerState = powerState;                                        // (R9)
        case (powerState)
            PKPD_OFF: begin
                if (doOn) next_powerState = PKPD_STANDBY;
            end
            PKPD_STANDBY: begin
                if (doForce || doSoft) next_powerState = PKPD_OFF;
                else if (doTapSl || doAuto) next_powerState = PKPD_SLEEPING;
            end
            PKPD_SLEEPING: begin
                if (doForce || doSoft) next_powerState = PKPD_OFF;
                else if (doWake) next_powerState = PKPD_STANDBY;
            end
            default: begin
                next_powerState = PKPD_OFF;
            end
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            powerState <= PKPD_OFF;
        end else begin
            powerState <= next_powerState;
        end
    end

    // One-shot guards for the held-key events
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            promptSent <= 1'b0;
            forceSent  <= 1'b0;
        end else if (!pressing) begin
            promptSent <= 1'b0;
            forceSent  <= 1'b0;
        end else begin
            promptSent <= promptSent | promptHit;
            forceSent  <= forceSent | forceHit;
        end
    end

    // Idle timer restarts while the power key is held or outside standby
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            idleMs <= '0;
        end else if (pressing || powerState != PKPD_STANDBY) begin
            idleMs <= '0;
        end else if (msTick && !idleDone) begin
            idleMs <= idleMs + 1'b1;                                         // (R7)
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Event outputs, one-cycle pulses

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            powerOnReq  <= 1'b0;
            forceOffReq <= 1'b0;
            sleepReq    <= 1'b0;
            wakeReq     <= 1'b0;
            promptReq   <= 1'b0;
        end else begin
            powerOnReq  <= doOn;                                             // (R2)
            forceOffReq <= doForce;                                          // (R4)
            sleepReq    <= (powerState == PKPD_STANDBY) && !doForce && !doSoft
                           && (doTapSl || doAuto);                           // (R5)
            wakeReq     <= (powerState == PKPD_SLEEPING) && !doForce && !doSoft
                           && doWake;                                        // (R6)
            promptReq   <= promptHit && !promptSent
                           && (powerState != PKPD_OFF);                      // (R3)
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Volume keys

    logic upPulse;
    logic downPulse;

    pkpd_key_filter #(.DEB_CYC(DEB_CYC)) uVolUp (
        .sys_clk    (sys_clk),
        .rst        (rst),
        .key_n      (volume_up_key_n),
        .pressed    (),
        .pressPulse (upPulse)
    );

    pkpd_key_filter #(.DEB_CYC(DEB_CYC)) uVolDown (
        .sys_clk    (sys_clk),
        .rst        (rst),
        .key_n      (volume_down_key_n),
        .pressed    (),
        .pressPulse (downPulse)
    );

    // Reported only while the module runs
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            volumeUpEvt   <= 1'b0;
            volumeDownEvt <= 1'b0;
        end else begin
            volumeUpEvt   <= upPulse && (powerState != PKPD_OFF);            // (R8)
            volumeDownEvt <= downPulse && (powerState != PKPD_OFF);          // (R8)
        end
    end
endmodule

//--- rtl/pkpd_defines.svh
// Contract
// (R1) Power key is active low; one input drives on, off, restart, sleep, wake.
// (R2) From off, a press held 2 s to 8 s starts the module.
// (R3) While running, a press over 0.5 s requests the shutdown or restart prompt.
// (R4) A press held 9 s to 15 s forces shutdown without software; the code forces off once the hold reaches 9 s and never checks 15 s.
// (R5) In standby, a 0.1 s press enters sleep.
// (R6) While sleeping, a 0.1 s press wakes the module.
// (R7) Standby enters sleep on its own after a software-set idle time.
// (R8) Two active-low volume keys, up and down, each reported when pressed; the code reports them only while powerState is not PKPD_OFF.
// (R9) Presses outside every window for the current state change nothing.
`ifndef PKPD_DEFINES_SVH
`define PKPD_DEFINES_SVH

// Clock rate in hertz
`define PKPD_CLK_HZ         25000000
// Window edges in milliseconds
`define PKPD_ON_MIN_MS      2000
`define PKPD_ON_MAX_MS      8000
`define PKPD_PROMPT_MS      500
`define PKPD_FORCE_MIN_MS   9000
`define PKPD_FORCE_MAX_MS   15000
`define PKPD_TAP_MS         100
// Cycle counts: least times round up, longest round down
`define PKPD_CYC_UP(ms)     ((64'(ms) * `PKPD_CLK_HZ + 999) / 1000)
`define PKPD_CYC_DN(ms)     ((64'(ms) * `PKPD_CLK_HZ) / 1000)
// Volume key debounce, 20 ms
`define PKPD_DEB_MS         20
// Width of the press duration counter
`define PKPD_CNT_W          30
// Width of the idle timeout value, in milliseconds
`define PKPD_IDLE_W         24
// Millisecond tick divider
`define PKPD_MS_DIV         `PKPD_CYC_DN(1)

`endif

//--- rtl/pkpd_pkg.sv
package pkpd_pkg;
    `include "pkpd_defines.svh"
    typedef logic [`PKPD_CNT_W-1:0]  pkpd_cnt_t;
    typedef logic [`PKPD_IDLE_W-1:0] pkpd_idle_t;
    typedef enum logic [1:0] {
        PKPD_OFF      = 2'b00,
        PKPD_STANDBY  = 2'b01,
        PKPD_SLEEPING = 2'b10
    } pkpd_state_e;
endpackage

//--- rtl/pkpd_key_filter.sv
`timescale 1ns/1ps
// Synchronises one active-low key and debounces it into a held level
module pkpd_key_filter #(
    parameter int unsigned DEB_CYC = 1
) (
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic rst,
    // Raw key, active low
    input  wire logic key_n,
    // Debounced pressed level and press pulse
    output logic      pressed,
    output logic      pressPulse
);
    logic        syncA;
    logic        syncB;
    logic [19:0] stable;
    wire         rawPressed = ~syncB;
    wire         settled    = (stable == 20'(DEB_CYC));

    // Two-stage synchroniser; only syncB is read by logic
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            syncA <= 1'b1;
            syncB <= 1'b1;
        end else begin
            syncA <= key_n;
            syncB <= syncA;
        end
    end

    // Debounce: contact bounce would otherwise cut presses into pieces
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            stable     <= 20'h00000;
            pressed    <= 1'b0;
            pressPulse <= 1'b0;
        end else begin
            pressPulse <= 1'b0;
            if (rawPressed == pressed) begin
                stable <= 20'h00000;
            end else if (settled) begin
                stable     <= 20'h00000;
                pressed    <= rawPressed;
                pressPulse <= rawPressed;
            end else begin
                stable <= stable + 20'h00001;
            end
        end
    end
endmodule

//--- tb/pkpd_monitor.sv
`timescale 1ns/1ps
module pkpd_monitor
    import pkpd_pkg::*;
#(
    parameter longint unsigned ON_MIN_CYC    = 200,
    parameter longint unsigned ON_MAX_CYC    = 800,
    parameter longint unsigned PROMPT_CYC    = 50,
    parameter longint unsigned FORCE_MIN_CYC = 900,
    parameter longint unsigned TAP_CYC       = 10
) (
    // Clock and reset
    input wire logic                  sys_clk,
    input wire logic                  rst,
    // Inputs watched
    input wire logic                  power_key_n,
    input wire logic                  volume_up_key_n,
    input wire logic                  volume_down_key_n,
    input wire logic                  softShutdown,
    // Outputs watched
    input wire pkpd_pkg::pkpd_state_e powerState,
    input wire logic                  powerOnReq,
    input wire logic                  forceOffReq,
    input wire logic                  sleepReq,
    input wire logic                  wakeReq,
    input wire logic                  promptReq,
    input wire logic                  volumeUpEvt,
    input wire logic                  volumeDownEvt
);
    import pkpd_pkg::*;
    logic [15:0] lowCnt, lastLow, pressLen, next_lowCnt, next_lastLow;
    ////////////////////////////////////////////////////////////
    // Press length at the raw pin; the last length covers the decode lag after release
    assign next_lowCnt  = power_key_n ? 16'h0000 : lowCnt + 16'h0001;
    assign next_lastLow = (power_key_n && lowCnt != 16'h0000) ? lowCnt : lastLow;
    assign pressLen     = (lowCnt != 16'h0000) ? lowCnt : lastLow;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            lowCnt  <= 16'h0000;
            lastLow <= 16'h0000;
        end else begin
            lowCnt  <= next_lowCnt;
            lastLow <= next_lastLow;
        end
    end
    ////////////////////////////////////////////////////////////
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence s_from(pkpd_state_e st); $past(powerState) == st; endsequence
    sequence s_into(pkpd_state_e st); powerState == st; endsequence
    property p_powerOn;
        powerOnReq |-> s_from(PKPD_OFF) ##0 s_into(PKPD_STANDBY)
            ##0 (pressLen + 1 >= ON_MIN_CYC && pressLen <= ON_MAX_CYC + 1);
    endproperty
    property p_prompt;
        promptReq |-> powerState != PKPD_OFF && pressLen >= PROMPT_CYC
            && pressLen <= PROMPT_CYC + 6;
    endproperty
    property p_force;
        forceOffReq |-> s_into(PKPD_OFF) ##0 (pressLen >= FORCE_MIN_CYC
            && pressLen <= FORCE_MIN_CYC + 6) ##1 s_into(PKPD_OFF) [*3];
    endproperty
    property p_sleep;
        sleepReq |-> s_from(PKPD_STANDBY) ##0 s_into(PKPD_SLEEPING);
    endproperty
    property p_wake;
        wakeReq |-> s_from(PKPD_SLEEPING) ##0 s_into(PKPD_STANDBY)
            ##0 (pressLen + 1 >= TAP_CYC && pressLen <= PROMPT_CYC + 1);
    endproperty
    property p_noStray;
        $changed(powerState) |-> powerOnReq || forceOffReq || sleepReq || wakeReq
            || $past(softShutdown);
    endproperty
    property p_volUp;
        volumeUpEvt |-> powerState != PKPD_OFF && !$past(volume_up_key_n, 3);
    endproperty
    property p_volDown;
        volumeDownEvt |-> powerState != PKPD_OFF && !$past(volume_down_key_n, 3);
    endproperty
    a_powerOn: assert property (p_powerOn) else $error("power-on outside its window");
    a_prompt: assert property (p_prompt) else $error("prompt at wrong time");
    a_force: assert property (p_force) else $error("forced off at wrong time");
    a_sleep: assert property (p_sleep) else $error("sleep entry wrong");
    a_wake: assert property (p_wake) else $error("wake-up wrong");
    a_noStray: assert property (p_noStray) else $error("state moved without cause");
    a_volUp: assert property (p_volUp) else $error("volume up event wrong");
    a_volDown: assert property (p_volDown) else $error("volume down event wrong");
endmodule

bind pkpd_power_key_decoder pkpd_monitor #(.ON_MIN_CYC(ON_MIN_CYC), .ON_MAX_CYC(ON_MAX_CYC),
    .PROMPT_CYC(PROMPT_CYC), .FORCE_MIN_CYC(FORCE_MIN_CYC), .TAP_CYC(TAP_CYC)) u_monitor (
    .sys_clk(sys_clk), .rst(rst), .power_key_n(power_key_n), .volume_up_key_n(volume_up_key_n),
    .volume_down_key_n(volume_down_key_n), .softShutdown(softShutdown),
    .powerState(powerState), .powerOnReq(powerOnReq), .forceOffReq(forceOffReq),
    .sleepReq(sleepReq), .wakeReq(wakeReq), .promptReq(promptReq),
    .volumeUpEvt(volumeUpEvt), .volumeDownEvt(volumeDownEvt));

//--- tb/pkpd_key_model.sv
`timescale 1ns/1ps
// Push buttons with pull-ups; a released key reads high
module pkpd_key_model (
    // Clock
    input wire logic sys_clk,
    // Key lines, active low
    output logic     powerKeyN,
    output logic     volUpKeyN,
    output logic     volDownKeyN
);
    initial begin
        powerKeyN   = 1'b1;
        volUpKeyN   = 1'b1;
        volDownKeyN = 1'b1;
    end
    ////////////////////////////////////////////////////////////
    // Hold one key low for a whole number of cycles, then let the pull-up return
    task automatic press(input int which, input int len);
        @(posedge sys_clk);
        if (which == 0) powerKeyN <= 1'b0;
        if (which == 1) volUpKeyN <= 1'b0;
        if (which == 2) volDownKeyN <= 1'b0;
        repeat (len) @(posedge sys_clk);
        powerKeyN   <= 1'b1;
        volUpKeyN   <= 1'b1;
        volDownKeyN <= 1'b1;
    endtask
endmodule

//--- tb/testbench.sv
`timescale 1ns/1ps
module testbench;
    import pkpd_pkg::*;
    localparam int TAP = 10;
    localparam int PROMPT = 50;
    localparam int ON_MIN = 200;
    localparam int ON_MAX = 800;
    localparam int FORCE_MIN = 900;
    localparam int MS_TICK = 5;
    logic        sysClk, rst, powerKeyN, volUpKeyN, volDownKeyN, autoSleepEn, softShutdown;
    logic        powerOnReq, forceOffReq, sleepReq, wakeReq, promptReq, volumeUpEvt, volumeDownEvt;
    logic [6:0]  pulses;
    pkpd_idle_t  autoSleepMs;
    pkpd_state_e powerState;
    int          errors = 0, comparisons = 0, expState = 0, seedDummy, wdog;
    int          cnt[7] = '{default: 0}, expCnt[7] = '{default: 0};
    int          kinds[$], lens[$];

    pkpd_power_key_decoder #(.ON_MIN_CYC(ON_MIN), .ON_MAX_CYC(ON_MAX), .PROMPT_CYC(PROMPT),
        .FORCE_MIN_CYC(FORCE_MIN), .FORCE_MAX_CYC(1500), .TAP_CYC(TAP), .MS_CYC(MS_TICK),
        .DEB_CYC(4))
    u_dut (.sys_clk(sysClk), .rst(rst), .power_key_n(powerKeyN), .volume_up_key_n(volUpKeyN),
        .volume_down_key_n(volDownKeyN), .autoSleepEn(autoSleepEn), .autoSleepMs(autoSleepMs),
        .softShutdown(softShutdown), .powerState(powerState), .powerOnReq(powerOnReq),
        .forceOffReq(forceOffReq), .sleepReq(sleepReq), .wakeReq(wakeReq), .promptReq(promptReq),
        .volumeUpEvt(volumeUpEvt), .volumeDownEvt(volumeDownEvt));
    pkpd_key_model u_keys (.sys_clk(sysClk), .powerKeyN(powerKeyN), .volUpKeyN(volUpKeyN),
        .volDownKeyN(volDownKeyN));
    ////////////////////////////////////////////////////////////
    // Count every output pulse, one slot per kind
    assign pulses = {volumeDownEvt, volumeUpEvt, promptReq, wakeReq, sleepReq, forceOffReq,
        powerOnReq};
    always @(posedge sysClk) begin
        for (int i = 0; i < 7; i++) cnt[i] += int'(pulses[i] === 1'b1);
    end
    initial begin
        sysClk = 1'b0;
        forever #20 sysClk = ~sysClk;
    end
    ////////////////////////////////////////////////////////////
    task automatic results();
        $display("Comparisons %0d, errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic report(input int got, input int exp);
        errors++;
        $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
    endtask
    task automatic chkState();
        comparisons++;
        if (powerState !== pkpd_state_e'(expState[1:0])) report(int'(powerState), expState);
    endtask
    task automatic chkCnt();
        for (int i = 0; i < 7; i++) begin
            comparisons++;
            if (cnt[i] != expCnt[i]) report(cnt[i], expCnt[i]);
        end
    endtask
    // A span in cycles must fall inside a tick-granular window
    task automatic chkSpan(input int got, input int lo, input int hi);
        comparisons++;
        if (got < lo || got > hi) report(got, lo);
    endtask
    // Reference model first, then the press itself; lengths stay clear of window edges
    task automatic doPress(input int kind, input int len);
        if (kind != 0) begin
            if (expState != 0) expCnt[4 + kind]++;
        end else if (expState == 0) begin
            if (len >= ON_MIN && len <= ON_MAX) expCnt[0]++;
            if (len >= ON_MIN && len <= ON_MAX) expState = 1;
        end else begin
            if (len >= PROMPT) expCnt[4]++;
            if (len >= FORCE_MIN) expCnt[1]++;
            if (len >= TAP && len < PROMPT) expCnt[1 + expState]++;
            if (len >= TAP && len < PROMPT) expState = 3 - expState;
            if (len >= FORCE_MIN) expState = 0;
        end
        u_keys.press(kind, len);
        repeat (12) @(posedge sysClk);
        chkState();
        chkCnt();
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        seedDummy = $urandom(32'hF47CE081);
        rst = 1'b1;
        autoSleepEn = 1'b0;
        autoSleepMs = '0;
        softShutdown = 1'b0;
        repeat (2) @(posedge sysClk);
        rst <= 1'b0;
        kinds = '{0, 1, 0, 0, 0, 0, 1, 2, 0, 0};
        lens = '{100, 20, ON_MIN + 10 + $urandom_range(580), TAP + 3 + $urandom_range(33),
            TAP + 3 + $urandom_range(33), 100, 20, 20, 950, ON_MIN + 10 + $urandom_range(580)};
        foreach (kinds[i]) doPress(kinds[i], lens[i]);
        @(posedge sysClk);
        autoSleepMs <= pkpd_idle_t'(2 + $urandom_range(3));
        autoSleepEn <= 1'b1;
        for (wdog = 0; wdog < 100 && powerState !== PKPD_SLEEPING; wdog++) @(posedge sysClk);
        // Idle time runs from the standby entry, nine cycles before the enable edge
        chkSpan(wdog + 8, MS_TICK * int'(autoSleepMs), MS_TICK * int'(autoSleepMs) + 10);
        repeat (2) @(posedge sysClk);
        expState = 2;
        expCnt[2]++;
        chkState();
        chkCnt();
        softShutdown <= 1'b1;
        @(posedge sysClk);
        softShutdown <= 1'b0;
        autoSleepEn <= 1'b0;
        repeat (3) @(posedge sysClk);
        expState = 0;
        chkState();
        results();
    end
    // Watchdog well past the few thousand cycles the sequence needs
    initial begin
        repeat (20000) @(posedge sysClk);
        errors++;
        results();
    end
endmodule
